/* scep_card.sv */
// Card end: 256-byte memory, protection bits, security area and the serial command engine.
// Assumes link pins are synchronous to CORE_CLK_IN and change no faster than a few core cycles.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module scep_card import scep_pkg::*; #(
  parameter int PHASE_CYC = PHASE_CYCLES,
  parameter logic [23:0] REF_CODE = DEF_REF_CODE
) (
  // Clock and power-on reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // Link
  scep_link_if.card LINK,
  // Status
  output logic UNLOCKED_OUT,
  output logic BUSY_OUT,
  output logic [2:0] FAIL_CNT_OUT
);
  localparam int TW = $clog2(2 * PHASE_CYC + 1);

  // Count of needed phases for one byte update
  function automatic logic [1:0] phase_cnt(input logic [7:0] old_v, input logic [7:0] new_v);
    phase_cnt = {1'b0, |(~old_v & new_v)} + {1'b0, |(old_v & ~new_v)};
  endfunction : phase_cnt

  // Stored byte after the erase and write phases
  function automatic logic [7:0] upd_val(input logic [7:0] old_v, input logic [7:0] new_v);
    upd_val = (|(~old_v & new_v)) ? new_v : (old_v & new_v);
  endfunction : upd_val

  logic [7:0] mem_r [MAIN_BYTES];
  logic prot_r [MAIN_BYTES];
  logic [7:0] sec_r [4];
  scep_dmode_t mode_r;
  scep_src_t src_r;
  scep_src_t op_tgt_r;
  logic clk_q_r, rst_q_r, io_q_r, oe_r, unlocked_r, op_en_r;
  logic rst_clk_r;
  logic [11:0] bit_r, total_r;
  logic [7:0] base_r, op_addr_r, op_val_r;
  logic [23:0] sr_r;
  logic [4:0] rc_r;
  logic [1:0] step_r, op_ph_r;
  logic [TW-1:0] timer_r;

  // Link events seen against last sampled levels
  logic clk_fall, clk_rise, atr_go, start_c, stop_c;
  assign clk_rise = LINK.card_clk & ~clk_q_r;
  assign clk_fall = ~LINK.card_clk & clk_q_r;
  // Only a reset that carried a clock pulse answers; a bare pulse is a break
  assign atr_go = ~LINK.card_rst & rst_q_r & rst_clk_r;
  assign start_c = io_q_r & ~LINK.io_level & LINK.card_clk & clk_q_r;
  assign stop_c = ~io_q_r & LINK.io_level & LINK.card_clk & clk_q_r;

  // Command fields, control first
  logic [7:0] ctl, adr, dat, old_main, old_sec;
  assign ctl = sr_r[7:0];
  assign adr = sr_r[15:8];
  assign dat = sr_r[23:16];
  assign old_main = mem_r[adr];
  assign old_sec = sec_r[adr[1:0]];

  // Command checks; anything not passing falls to a silent release
  logic frame_ok, is_rd, is_upd_main, is_wprot, is_upd_sec, is_cmp;
  logic main_lock, upd_main_ok, wprot_ok, upd_sec_ok, cmp_match, arm_cnt, go_proc;
  assign frame_ok = (rc_r == CMD_CLKS);
  assign is_rd = (ctl == CMD_READ_MAIN) | (ctl == CMD_READ_PROT) | (ctl == CMD_READ_SEC);
  assign is_upd_main = (ctl == CMD_UPD_MAIN);
  assign is_wprot = (ctl == CMD_WRITE_PROT);
  assign is_upd_sec = (ctl == CMD_UPD_SEC);
  assign is_cmp = (ctl == CMD_CODE_CHECK);
  assign main_lock = (adr < WPROT_LIMIT) & prot_r[adr];
  assign upd_main_ok = unlocked_r & ~main_lock;
  assign wprot_ok = unlocked_r & ~prot_r[adr];
  assign upd_sec_ok = (adr < SEC_BYTES) &
                      (unlocked_r | ((adr == 8'h00) & (phase_cnt(old_sec, dat) != 2'h0) &
                                     ~|(~old_sec & dat)));
  // Compare only after a counter bit was spent, in byte order
  assign cmp_match = (step_r != 2'h0) & (adr == {6'h00, step_r}) & (dat == old_sec);
  assign arm_cnt = is_upd_sec & upd_sec_ok & ~unlocked_r;
  assign go_proc = (is_upd_main & upd_main_ok) | (is_wprot & wprot_ok) |
                   (is_upd_sec & upd_sec_ok) | (is_cmp & cmp_match);

  // Read stream total: to memory end for main, 32 bits otherwise
  logic [11:0] rd_total;
  assign rd_total = (ctl == CMD_READ_MAIN) ? {9'h100 - {1'b0, adr}, 3'h0} : SHORT_READ_BITS;

  // Processing op chosen at the stop condition
  scep_src_t op_tgt;
  logic [1:0] op_ph;
  logic [7:0] op_val;
  assign op_tgt = is_upd_main ? SRC_MAIN : (is_wprot ? SRC_PROT : SRC_SEC);
  assign op_val = is_upd_sec ? upd_val(old_sec, dat) : upd_val(old_main, dat);
  assign op_ph = is_cmp ? 2'h0 :
                 (is_wprot ? {1'b0, dat == old_main} :
                  (is_upd_sec ? phase_cnt(old_sec, dat) : phase_cnt(old_main, dat)));

  // Outgoing bit selection
  logic [7:0] byte_ix;
  logic main_bit, prot_bit, sec_bit, cur_bit;
  assign byte_ix = base_r + bit_r[10:3];
  assign main_bit = mem_r[byte_ix][bit_r[2:0]] &
                    ~((byte_ix >= WPROT_LIMIT) & prot_r[byte_ix] & ~unlocked_r);
  assign prot_bit = prot_r[{3'h0, bit_r[4:0]}];
  assign sec_bit = sec_r[bit_r[4:3]][bit_r[2:0]] & (unlocked_r | (bit_r[4:3] == 2'h0));
  assign cur_bit = (src_r == SRC_MAIN) ? main_bit : ((src_r == SRC_PROT) ? prot_bit : sec_bit);

  // Outputs straight from flops
  assign LINK.card_io_oe = oe_r;
  assign UNLOCKED_OUT = unlocked_r;
  assign BUSY_OUT = ~mode_r[0];
  assign FAIL_CNT_OUT = sec_r[0][2:0];

  // Storage; reset here stands for a fresh blank part at power-up
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < MAIN_BYTES; i++) begin
        mem_r[i] <= MAIN_RESET;
        prot_r[i] <= 1'b0;
      end
      sec_r[0] <= CNT_RESET;
      sec_r[1] <= REF_CODE[7:0];
      sec_r[2] <= REF_CODE[15:8];
      sec_r[3] <= REF_CODE[23:16];
    end else if (!LINK.card_rst && mode_r == DM_PRUN && clk_fall && timer_r == '0 && op_en_r) begin
      // Commit only at the end, so a break leaves memory untouched
      unique case (op_tgt_r)
        SRC_MAIN: mem_r[op_addr_r] <= op_val_r;
        SRC_PROT: prot_r[op_addr_r] <= 1'b1;
        // Counter byte keeps only its three counter bits
        default: sec_r[op_addr_r[1:0]] <= (op_addr_r[1:0] == 2'h0) ? {5'h00, op_val_r[2:0]} : op_val_r;
      endcase
    end
  end

  // Link engine
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      mode_r <= DM_IDLE;
      src_r <= SRC_MAIN;
      op_tgt_r <= SRC_MAIN;
      {clk_q_r, rst_q_r, io_q_r, oe_r, unlocked_r, op_en_r} <= 6'h04;
      {bit_r, total_r} <= 24'h000000;
      {base_r, op_addr_r, op_val_r} <= 24'h000000;
      sr_r <= 24'h000000;
      rc_r <= 5'h00;
      step_r <= 2'h0;
      op_ph_r <= 2'h0;
      timer_r <= '0;
      rst_clk_r <= 1'b0;
    end else begin
      rst_clk_r <= LINK.card_rst & (clk_rise | (rst_q_r & rst_clk_r));
      clk_q_r <= LINK.card_clk;
      rst_q_r <= LINK.card_rst;
      io_q_r <= LINK.io_level;
      if (timer_r != '0) begin
        timer_r <= timer_r - 1'b1;
      end
      if (LINK.card_rst) begin
        // Reset pin high aborts everything and frees the wire
        mode_r <= DM_IDLE;
        oe_r <= 1'b0;
      end else if (atr_go) begin
        // First answer bit goes out with the reset release itself
        mode_r <= DM_OUT;
        src_r <= SRC_MAIN;
        base_r <= 8'h00;
        bit_r <= 12'h001;
        total_r <= ATR_BITS;
        oe_r <= ~mem_r[0][0];
      end else begin
        unique case (mode_r)
          DM_IDLE: begin
            if (start_c) begin
              mode_r <= DM_CMD;
              rc_r <= 5'h00;
            end
          end
          DM_CMD: begin
            if (start_c) begin
              rc_r <= 5'h00;
            end else if (stop_c) begin
              step_r <= 2'h0;
              if (frame_ok && is_rd) begin
                mode_r <= DM_OUT;
                src_r <= (ctl == CMD_READ_MAIN) ? SRC_MAIN : ((ctl == CMD_READ_PROT) ? SRC_PROT : SRC_SEC);
                base_r <= (ctl == CMD_READ_MAIN) ? adr : 8'h00;
                bit_r <= 12'h000;
                total_r <= rd_total;
              end else if (frame_ok && go_proc) begin
                mode_r <= DM_PWAIT;
                op_tgt_r <= op_tgt;
                op_addr_r <= adr;
                op_val_r <= op_val;
                op_ph_r <= op_ph;
                op_en_r <= ~is_cmp & (op_ph != 2'h0);
                if (arm_cnt) begin
                  step_r <= 2'h1;
                end else if (is_cmp && adr != 8'h03) begin
                  step_r <= step_r + 2'h1;
                end else if (is_cmp) begin
                  unlocked_r <= 1'b1;
                end
              end else begin
                mode_r <= DM_IDLE;
              end
            end else if (clk_rise) begin
              if (rc_r < CMD_CLKS - 5'h01) begin
                sr_r <= {LINK.io_level, sr_r[23:1]};
              end
              if (rc_r != 5'h1F) begin
                rc_r <= rc_r + 5'h01;
              end
            end
          end
          DM_OUT: begin
            // Framing edges are ignored while streaming
            if (clk_fall) begin
              if (bit_r == total_r) begin
                oe_r <= 1'b0;
                mode_r <= DM_IDLE;
              end else begin
                oe_r <= ~cur_bit;
                bit_r <= bit_r + 12'h001;
              end
            end
          end
          DM_PWAIT: begin
            if (clk_fall) begin
              oe_r <= 1'b1;
              mode_r <= DM_PRUN;
              timer_r <= TW'(op_ph_r) * TW'(PHASE_CYC);
            end
          end
          default: begin
            // Release only on a fall after the phase time has run out
            if (clk_fall && timer_r == '0) begin
              oe_r <= 1'b0;
              mode_r <= DM_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : scep_card
`default_nettype wire

/* scep_pkg.sv */
// Constants, command codes and state codes shared by both ends of the card link.
// Assumes a single 250 MHz core clock on both ends; link pins are plain synchronous levels.
// Notes on behaviour
// - Erase sets all eight byte bits
// - Write result is old AND new
// - Skip needless erase or write phase
// - Each phase lasts at least 2.5 ms
// - Protected low 32 bytes never change
// - Protected upper bytes unreadable until unlocked
// - Security area: counter plus three code bytes
// - Writes need unlock; unlock lasts until power-off
// - Three failed compares block all verification
// - Card changes data only on clock fall; here the first answer bit goes out at reset release
// - Reset answer: 32 bits, 33rd clock releases
// - Start, three bytes, extra clock, stop
// - Start/stop are data edges, clock high
// - Read mode: bits, extra clock, ignore framing
// - Processing holds line low, ignores framing
// - Reset high with clock low aborts
// - Bytes control, address, data, LSB first
// - Seven control codes, reads versus processing
// - Host: decrement counter, compare three, erase
// - Failures release line within eight clocks
// - Locked security read shows code bytes low
// - Locked security update only clears counter
package scep_pkg;
  // Timing
  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam real PHASE_TIME_MS = 2.5;
  localparam int PHASE_CYCLES = int'($ceil(PHASE_TIME_MS * 1.0e6 / CORE_CLK_PERIOD_NS));
  localparam int LINK_CLK_KHZ = 50;
  localparam int LINK_HALF_CYCLES = 1000000 / (2 * LINK_CLK_KHZ * CORE_CLK_PERIOD_NS);
  // Memory shape
  localparam int MAIN_BYTES = 256;
  localparam logic [7:0] WPROT_LIMIT = 8'h20;
  localparam logic [7:0] SEC_BYTES = 8'h04;
  localparam logic [7:0] MAIN_RESET = 8'hFF;
  localparam logic [7:0] CNT_RESET = 8'h07;
  localparam logic [23:0] DEF_REF_CODE = 24'h5A3C96; // Arbitrary default code
  // Frame and stream lengths
  localparam int CMD_BITS = 24;
  localparam logic [4:0] CMD_CLKS = 5'h19;
  localparam logic [11:0] ATR_BITS = 12'h020;
  localparam logic [11:0] SHORT_READ_BITS = 12'h020;
  localparam logic [11:0] ATR_CLKS = 12'h021;
  // Control codes
  localparam logic [7:0] CMD_READ_MAIN = 8'h30;
  localparam logic [7:0] CMD_UPD_MAIN = 8'h38;
  localparam logic [7:0] CMD_READ_PROT = 8'h34;
  localparam logic [7:0] CMD_WRITE_PROT = 8'h3C;
  localparam logic [7:0] CMD_READ_SEC = 8'h31;
  localparam logic [7:0] CMD_UPD_SEC = 8'h39;
  localparam logic [7:0] CMD_CODE_CHECK = 8'h33;
  // Reader register map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_CLKS = 8'h08;
  localparam logic [7:0] REG_RX = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_CMD_BIT = 0;
  localparam int CTRL_ATR_BIT = 1;
  localparam int CTRL_BREAK_BIT = 2;
  localparam logic [11:0] CLKS_RESET = 12'h000;
  // Card operating modes
  typedef enum logic [4:0] {
    DM_IDLE = 5'b00001, DM_CMD = 5'b00010, DM_OUT = 5'b00100,
    DM_PWAIT = 5'b01000, DM_PRUN = 5'b10000
  } scep_dmode_t;
  // Read stream sources and processing targets
  typedef enum logic [1:0] {SRC_MAIN = 2'h0, SRC_PROT = 2'h1, SRC_SEC = 2'h2} scep_src_t;
  // Reader sequencer states
  typedef enum logic [6:0] {
    H_IDLE = 7'b0000001, H_RST = 7'b0000010, H_BRK = 7'b0000100, H_START = 7'b0001000,
    H_BITS = 7'b0010000, H_STOP = 7'b0100000, H_CLK = 7'b1000000
  } scep_hstate_t;
endpackage : scep_pkg

/* scep_link_if.sv */
// Three-wire card link: reader-made clock and reset, one open-drain data wire.
// Assumes both ends sit on the same core clock; the wire level is the AND of released drivers.
`timescale 1ns/1ns
`default_nettype none
interface scep_link_if;
  logic card_clk;
  logic card_rst;
  logic host_io_oe;
  logic card_io_oe;
  logic io_level;
  // Pull-up gives high unless some end pulls low
  assign io_level = ~(host_io_oe | card_io_oe);
  modport card (input card_clk, input card_rst, input io_level, output card_io_oe);
  modport reader (output card_clk, output card_rst, output host_io_oe, input io_level);
endinterface : scep_link_if
`default_nettype wire

/* scep_reader.sv */
// Reader end: makes link clock and reset, frames commands, clocks and samples answers.
// Assumes software drives the plain register port; one core clock for everything.
`timescale 1ns/1ns
`default_nettype none
module scep_reader import scep_pkg::*; #(
  parameter int HALF_CYC = LINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // Link
  scep_link_if.reader LINK
);
  localparam int DW = $clog2(HALF_CYC + 1);

  scep_hstate_t state_r;
  logic [DW-1:0] div_r;
  logic [5:0] sub_r, nsmp_r;
  logic [11:0] cnt_r, clks_r;
  logic [23:0] cmd_r;
  logic [31:0] rx_r, rdata_r;
  logic clk_r, rst_r, oe_r;

  // Half-period tick paces every link step
  logic tick, idle, ctrl_wr;
  assign tick = (div_r == '0);
  assign idle = (state_r == H_IDLE);
  assign ctrl_wr = WR_IN & (ADDR_IN == REG_CTRL) & idle;

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  assign rd_mux = (ADDR_IN == REG_CMD) ? {8'h00, cmd_r} :
                  (ADDR_IN == REG_CLKS) ? {20'h00000, clks_r} :
                  (ADDR_IN == REG_RX) ? rx_r :
                  (ADDR_IN == REG_STATUS) ? {30'h00000000, LINK.io_level, ~idle} : 32'h00000000;

  assign LINK.card_clk = clk_r;
  assign LINK.card_rst = rst_r;
  assign LINK.host_io_oe = oe_r;
  assign RDATA_OUT = rdata_r;

  // Register port
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      cmd_r <= 24'h000000;
      clks_r <= CLKS_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= RD_IN ? rd_mux : 32'h00000000;
      if (WR_IN && ADDR_IN == REG_CMD) begin
        cmd_r <= WDATA_IN[23:0];
      end
      if (WR_IN && ADDR_IN == REG_CLKS) begin
        clks_r <= WDATA_IN[11:0];
      end
    end
  end

  // Link sequencer
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      state_r <= H_IDLE;
      div_r <= '0;
      {sub_r, nsmp_r} <= 12'h000;
      cnt_r <= 12'h000;
      rx_r <= 32'h00000000;
      {clk_r, rst_r, oe_r} <= 3'h0;
    end else begin
      div_r <= tick ? DW'(HALF_CYC - 1) : div_r - 1'b1;
      if (ctrl_wr) begin
        sub_r <= 6'h00;
        state_r <= WDATA_IN[CTRL_ATR_BIT] ? H_RST :
                   (WDATA_IN[CTRL_BREAK_BIT] ? H_BRK : (WDATA_IN[CTRL_CMD_BIT] ? H_START : H_IDLE));
      end else if (tick && !idle) begin
        sub_r <= sub_r + 6'h01;
        unique case (state_r)
          H_RST: begin
            // Reset high, one clock pulse, reset low: card answers
            if (sub_r == 6'h00) rst_r <= 1'b1;
            if (sub_r == 6'h01) clk_r <= 1'b1;
            if (sub_r == 6'h02) clk_r <= 1'b0;
            if (sub_r == 6'h03) begin
              rst_r <= 1'b0;
              cnt_r <= ATR_CLKS;
              {sub_r, nsmp_r} <= 12'h000;
              rx_r <= 32'h00000000;
              state_r <= H_CLK;
            end
          end
          H_BRK: begin
            // Clock is low here, so the pulse is a break
            rst_r <= (sub_r == 6'h00);
            if (sub_r != 6'h00) state_r <= H_IDLE;
          end
          H_START: begin
            if (sub_r == 6'h00) clk_r <= 1'b1;
            if (sub_r == 6'h01) oe_r <= 1'b1;
            if (sub_r == 6'h02) begin
              clk_r <= 1'b0;
              sub_r <= 6'h00;
              state_r <= H_BITS;
            end
          end
          H_BITS: begin
            // 24 bits LSB first, then the spare clock with the wire low; its high phase carries the stop
            if (!sub_r[0]) begin
              clk_r <= 1'b0;
              oe_r <= (sub_r[5:1] < 5'h18) ? ~cmd_r[sub_r[5:1]] : 1'b1;
            end else begin
              clk_r <= 1'b1;
            end
            if (sub_r == 6'h31) begin
              sub_r <= 6'h00;
              state_r <= H_STOP;
            end
          end
          H_STOP: begin
            // A separate stop pulse would be a 26th clock and the card would refuse the frame
            if (sub_r == 6'h00) oe_r <= 1'b0;
            // This fall is the card's first answer edge
            if (sub_r == 6'h01) clk_r <= 1'b0;
            if (sub_r == 6'h02) begin
              cnt_r <= clks_r;
              {sub_r, nsmp_r} <= 12'h000;
              state_r <= H_CLK;
            end
          end
          default: begin
            // Answer clocks; sample on the rise, card moves on the fall
            if (cnt_r == 12'h000) begin
              state_r <= H_IDLE;
            end else if (!sub_r[0]) begin
              clk_r <= 1'b1;
              if (nsmp_r < 6'h20) begin
                rx_r <= {LINK.io_level, rx_r[31:1]};
                nsmp_r <= nsmp_r + 6'h01;
              end
            end else begin
              clk_r <= 1'b0;
              cnt_r <= cnt_r - 12'h001;
            end
          end
        endcase
      end
    end
  end
endmodule : scep_reader
`default_nettype wire

/* scep_link_asserts.sv */
// Link checker: card wires and card status beside the joined link.
// Assumes one core clock; link pins sampled on it.
`timescale 1ns/1ns
`default_nettype none
module scep_link_asserts (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // Link wires
  input wire logic card_clk,
  input wire logic card_rst,
  input wire logic card_io_oe,
  input wire logic io_level,
  // Card status
  input wire logic UNLOCKED_OUT,
  input wire logic [2:0] FAIL_CNT_OUT
);
  logic clk_d_r;
  logic rst_d_r;
  logic atr_on_r;
  logic [4:0] atr_cnt_r;
  wire clk_fall = clk_d_r & ~card_clk;
  wire atr_end = atr_on_r & clk_fall & (atr_cnt_r == 5'h1F);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Falls after a clocked reset; a break has no clock pulse so it starts nothing
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      clk_d_r <= 1'b0;
      rst_d_r <= 1'b0;
      atr_on_r <= 1'b0;
      atr_cnt_r <= 5'h00;
    end else begin
      clk_d_r <= card_clk;
      rst_d_r <= card_rst;
      if (card_rst) begin
        atr_cnt_r <= 5'h00;
        atr_on_r <= card_clk | (atr_on_r & rst_d_r);
      end else if (atr_end) begin
        atr_on_r <= 1'b0;
      end else if (atr_on_r & clk_fall) begin
        atr_cnt_r <= atr_cnt_r + 5'h01;
      end
    end
  end
  // Wire and security relations
  property p_io_clk_low;
    $changed(card_io_oe) |-> !card_clk;
  endproperty
  a_io_clk_low: assert property (p_io_clk_low) else $error("card data moved with link clock high");
  property p_rise_held;
    $rose(card_io_oe) |-> !card_clk [*3];
  endproperty
  a_rise_held: assert property (p_rise_held) else $error("card pulled low too near a rise");
  property p_rst_release;
    card_rst [*3] |-> !card_io_oe;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("card drives during link reset");
  property p_atr_release;
    atr_end |-> ##3 !card_io_oe [*4];
  endproperty
  a_atr_release: assert property (p_atr_release) else $error("answer not released on last clock");
  property p_unlock_sticky;
    UNLOCKED_OUT |=> UNLOCKED_OUT;
  endproperty
  a_unlock_sticky: assert property (p_unlock_sticky) else $error("unlock dropped");
  property p_cnt_no_set;
    !UNLOCKED_OUT |=> (FAIL_CNT_OUT & ~$past(FAIL_CNT_OUT)) == 3'h0;
  endproperty
  a_cnt_no_set: assert property (p_cnt_no_set) else $error("counter bit set while locked");
  property p_dead_cnt;
    (FAIL_CNT_OUT == 3'h0) && !UNLOCKED_OUT |=> !UNLOCKED_OUT;
  endproperty
  a_dead_cnt: assert property (p_dead_cnt) else $error("unlock with empty counter");
  property p_unlock_try;
    $rose(UNLOCKED_OUT) |-> FAIL_CNT_OUT != 3'h7;
  endproperty
  a_unlock_try: assert property (p_unlock_try) else $error("unlock without spent counter bit");
  c_unlock: cover property ($rose(UNLOCKED_OUT));
  c_atr: cover property (atr_end);
  c_dead: cover property (FAIL_CNT_OUT == 3'h0);
  c_start: cover property (card_clk && $fell(io_level));
endmodule : scep_link_asserts
`default_nettype wire

/* tb_secure_card_eeprom_protocol.sv */
// Bench: reader and card on one link, driven through the reader register port.
// Assumes shortened phase and link half-period parameters.
`timescale 1ns/1ns
`default_nettype none
module tb_secure_card_eeprom_protocol import scep_pkg::*; ;
  localparam int PC = 50;
  localparam int HC = 8;
  localparam logic [23:0] REF = 24'h1E2D4B; // Arbitrary code
  localparam int LIMIT = 90000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic unlocked;
  logic busy;
  logic [2:0] fail_cnt;
  logic [31:0] rx;
  logic [31:0] st;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  scep_link_if link ();
  scep_card #(.PHASE_CYC(PC), .REF_CODE(REF)) u_scep_card (.CORE_CLK_IN(core_clk), .RST_N_IN(rst_n),
    .LINK(link), .UNLOCKED_OUT(unlocked), .BUSY_OUT(busy), .FAIL_CNT_OUT(fail_cnt));
  scep_reader #(.HALF_CYC(HC)) u_scep_reader (.CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .LINK(link));
  scep_link_asserts u_scep_link_asserts (.CORE_CLK_IN(core_clk), .RST_N_IN(rst_n),
    .card_clk(link.card_clk), .card_rst(link.card_rst), .card_io_oe(link.card_io_oe),
    .io_level(link.io_level), .UNLOCKED_OUT(unlocked), .FAIL_CNT_OUT(fail_cnt));
  always #2 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      $display("MISMATCH t=%0t timeout", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge core_clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge core_clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Start an action, wait for the reader under a bound, fetch the samples
  task automatic go(input logic [31:0] ctl);
    int k = 0;
    wr(REG_CTRL, ctl);
    st = 32'h1;
    while (st[0] !== 1'b0 && k < 3000) begin
      rd(REG_STATUS, st);
      k++;
    end
    chk({31'h0, k < 3000}, 32'h1, "reader done");
    rd(REG_RX, rx);
  endtask : go
  task automatic send(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input logic [11:0] n);
    wr(REG_CMD, {8'h00, d, a, c});
    wr(REG_CLKS, {20'h0, n});
    go(32'h1);
  endtask : send
  // Twelve answer clocks; the low run length tells phase count, zero means refused
  task automatic run_proc(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input int lo, input int hi);
    int z;
    send(c, a, d, 12'h00C);
    z = 12 - $countones(rx[31:20]);
    chk({31'h0, z >= lo && z <= hi && rx[31] === 1'b1}, 32'h1, "low run length");
  endtask : run_proc
  task automatic t_atr();
    go(32'h2);
    chk(rx, 32'hFFFFFFFF, "answer to reset");
    rd(REG_STATUS, st);
    chk(st, 32'h2, "line released");
    $display("test atr done");
  endtask : t_atr
  task automatic t_unlock();
    send(CMD_READ_SEC, 8'h00, 8'h00, 12'h021);
    chk(rx, 32'h7, "locked security read");
    run_proc(CMD_UPD_MAIN, 8'h02, 8'h00, 0, 0);
    run_proc(CMD_UPD_SEC, 8'h01, 8'h00, 0, 0);
    run_proc(CMD_UPD_SEC, 8'h00, 8'h06, 3, 5);
    chk({29'h0, fail_cnt}, 32'h6, "counter bit spent");
    for (int i = 1; i < 4; i++) begin
      run_proc(CMD_CODE_CHECK, i[7:0], REF[8*i-8 +: 8], 0, 2);
    end
    chk({31'h0, unlocked}, 32'h1, "unlocked");
    run_proc(CMD_UPD_SEC, 8'h00, 8'hFF, 3, 5);
    chk({29'h0, fail_cnt}, 32'h7, "counter erased");
    send(CMD_READ_SEC, 8'h00, 8'h00, 12'h021);
    chk(rx, {REF, 8'h07}, "security read");
    $display("test unlock done");
  endtask : t_unlock
  task automatic t_update();
    run_proc(CMD_UPD_MAIN, 8'h02, 8'hF0, 3, 5);
    run_proc(CMD_UPD_MAIN, 8'h02, 8'h0F, 6, 8);
    run_proc(CMD_UPD_MAIN, 8'h02, 8'h0F, 0, 2);
    go(32'h2);
    chk(rx, 32'hFF0FFFFF, "bytes after update");
    run_proc(CMD_UPD_MAIN, 8'hFC, 8'h5A, 3, 5);
    send(CMD_READ_MAIN, 8'hFC, 8'h00, 12'h021);
    chk(rx, 32'hFFFFFF5A, "main tail read");
    $display("test update done");
  endtask : t_update
  task automatic t_protect();
    run_proc(CMD_WRITE_PROT, 8'h02, 8'h55, 0, 2);
    run_proc(CMD_WRITE_PROT, 8'h02, 8'h0F, 3, 5);
    run_proc(CMD_UPD_MAIN, 8'h02, 8'h55, 0, 0);
    run_proc(CMD_WRITE_PROT, 8'h02, 8'h0F, 0, 0);
    send(CMD_READ_PROT, 8'h00, 8'h00, 12'h021);
    chk(rx, 32'h4, "protection bits");
    go(32'h2);
    chk(rx, 32'hFF0FFFFF, "protected byte kept");
    $display("test protect done");
  endtask : t_protect
  // Break in mid stream: counter byte bit five is low on the wire
  task automatic t_break();
    run_proc(8'h3F, 8'h00, 8'h00, 0, 0);
    send(CMD_READ_SEC, 8'h00, 8'h00, 12'h005);
    rd(REG_STATUS, st);
    chk(st, 32'h0, "stream holds low bit");
    chk({31'h0, busy}, 32'h1, "card mid stream");
    go(32'h4);
    rd(REG_STATUS, st);
    chk(st, 32'h2, "break released line");
    chk({31'h0, busy}, 32'h0, "card idle after break");
    $display("test break done");
  endtask : t_break
  // Power cycle relocks; three failed tries use up the counter
  task automatic t_lockout();
    logic [2:0] cn;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    go(32'h2);
    for (int i = 0; i < 3; i++) begin
      cn = 3'h6 << i;
      run_proc(CMD_UPD_SEC, 8'h00, {5'h00, cn}, 3, 5);
      run_proc(CMD_CODE_CHECK, 8'h01, ~REF[7:0], 0, 0);
      chk({29'h0, fail_cnt}, {29'h0, cn}, "counter after fail");
    end
    run_proc(CMD_UPD_SEC, 8'h00, 8'h07, 0, 0);
    run_proc(CMD_UPD_SEC, 8'h00, 8'h00, 0, 2);
    run_proc(CMD_CODE_CHECK, 8'h01, REF[7:0], 0, 0);
    chk({31'h0, unlocked}, 32'h0, "still locked");
    $display("test lockout done");
  endtask : t_lockout
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_atr();
    t_unlock();
    t_update();
    t_protect();
    t_break();
    t_lockout();
    close_out();
  end
endmodule : tb_secure_card_eeprom_protocol
`default_nettype wire
